// ---- core/ddr2_wr_consts.vh ----
// Purpose: Constants for the DDR2 write burst path.
// Assumes: Included by its bare name from the design file.
// Notes:   Definitions only.
`ifndef DDR2_WR_CONSTS_VH
`define DDR2_WR_CONSTS_VH

// Register byte addresses on APB
`define ADDR_CFG      8'h00
`define ADDR_STAT     8'h04
`define ADDR_WCNT     8'h08

// Register select codes
`define SEL_NONE      2'h0
`define SEL_CFG       2'h1
`define SEL_STAT      2'h2
`define SEL_WCNT      2'h3

// Configuration fields and reset values
`define CFG_BL8_BIT   0
`define CFG_WR_LSB    4
`define CFG_WR_MSB    6
`define CFG_WTR_LSB   8
`define CFG_WTR_MSB   10
`define BL8_RST       1'b0
`define WR_RST        3'h3
`define WTR_RST       3'h2

// Status fields
`define ST_BUSY_BIT   8
`define ST_VINT_BIT   9
`define ST_VWTR_BIT   10
`define ST_VWR_BIT    11
`define ST_QCNT_LSB   12
`define ST_QCNT_MSB   14

// Command codes {ras_n, cas_n, we_n}
`define CMD_WRITE     3'h4
`define CMD_READ      3'h5
`define CMD_ACT       3'h3
`define CMD_PRE       3'h2

// Timing in clock edges of ck
`define WTR_MIN       4'h2
`define TRUNC_GAP     4'h1
`define CNT_SAT       4'hF

// Write queue entry {bl8, auto_pre, col[9:0], bank[2:0]}
`define E_BANK_LSB    0
`define E_BANK_MSB    2
`define E_COL_LSB     3
`define E_COL_MSB     12
`define E_AP_BIT      13
`define E_BL8_BIT     14
`define Q_CNT_FULL    3'h4

`endif

// ---- core/ddr2_write_burst_path.v ----
// Purpose: Write path of an 8-bank DDR2 memory: command decode, strobe capture,
//          burst queueing, truncation, bank state and turnaround checking.
// Assumes: mclk far faster than ck and dqs; all memory-bus pins pass two flip-flops first, the APB pins do not.
// Notes:   Sequential column order only; violations are sticky status bits.
//
// The register addresses and register access over APB are this design's own decisions.
`include "ddr2_wr_consts.vh"

module ddr2_write_burst_path (
   input  wire        mclk,
   input  wire        nrst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        ck,
   input  wire        cs_n,
   input  wire        ras_n,
   input  wire        cas_n,
   input  wire        we_n,
   input  wire [2:0]  ba,
   input  wire [13:0] addr,
   input  wire [1:0]  dm,
   input  wire        dqs_l,
   input  wire        dqs_u,
   input  wire [15:0] dq_in,
   output reg  [15:0] dq_out,
   output reg         dq_oe_n,
   output reg         wr_valid,
   output reg  [2:0]  wr_bank,
   output reg  [9:0]  wr_col,
   output reg  [15:0] wr_data,
   output reg  [1:0]  wr_mask
);

   // Command decode qualified by ck edge and chip select
   function cmd_hit;
      input       en;
      input [2:0] c;
      input [2:0] code;
      begin
         cmd_hit = en && (c == code);
      end
   endfunction

   // Precharge hits a bank when all-bank or bank address matches
   function pre_hits;
      input       all;
      input [2:0] pb;
      input [2:0] b;
      begin
         pre_hits = all || (pb == b);
      end
   endfunction

   // APB register select
   function [1:0] reg_sel;
      input [7:0] a;
      begin
         if (a == `ADDR_CFG) begin
            reg_sel = `SEL_CFG;
         end else if (a == `ADDR_STAT) begin
            reg_sel = `SEL_STAT;
         end else if (a == `ADDR_WCNT) begin
            reg_sel = `SEL_WCNT;
         end else begin
            reg_sel = `SEL_NONE;
         end
      end
   endfunction

   localparam SW = 42;

   wire [SW-1:0] pins_raw = {ck, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dqs_u, dqs_l, dq_in};
   reg  [SW-1:0] s1_r;
   reg  [SW-1:0] s2_r;
   reg  [2:0]    s3_r;

   // Two-stage synchroniser, plus a third stage for edge detection
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= {SW{1'b0}};
         s2_r <= {SW{1'b0}};
         s3_r <= 3'h0;
      end else begin
         s1_r <= pins_raw;
         s2_r <= s1_r;
         s3_r <= {s2_r[41], s2_r[17], s2_r[16]};
      end
   end

   wire        ck_rise  = s2_r[41] & ~s3_r[2];
   wire        cmd_en   = ck_rise & ~s2_r[40];
   wire [2:0]  cmd      = s2_r[39:37];
   wire [2:0]  cmd_bank = s2_r[36:34];
   wire        a10      = s2_r[30];
   wire [9:0]  cmd_col  = s2_r[29:20];
   wire [1:0]  dqs_now  = s2_r[17:16];
   wire [1:0]  dqs_prv  = s3_r[1:0];

   wire wr_cmd  = cmd_hit(cmd_en, cmd, `CMD_WRITE);
   wire rd_cmd  = cmd_hit(cmd_en, cmd, `CMD_READ);
   wire act_cmd = cmd_hit(cmd_en, cmd, `CMD_ACT);
   wire pre_cmd = cmd_hit(cmd_en, cmd, `CMD_PRE);

   reg  [14:0] q_mem [0:3];
   reg  [1:0]  q_head_r;
   reg  [1:0]  q_tail_r;
   reg  [2:0]  q_cnt_r;
   reg  [3:0]  widx_r;
   reg  [3:0]  gap_r;
   reg  [3:0]  since_end_r;
   reg  [2:0]  last_bank_r;
   reg  [7:0]  bank_open_r;
   reg  [7:0]  bank_nxt;
   reg         cfg_bl8_r;
   reg  [2:0]  wr_cfg_r;
   reg  [2:0]  wtr_cfg_r;
   reg  [2:0]  viol_r;
   reg  [15:0] wcnt_r;
   reg  [31:0] rd_mux;

   wire [1:0]  tail_prev = q_tail_r - 2'h1;
   wire [14:0] head      = q_mem[q_head_r];
   wire [14:0] last      = q_mem[tail_prev];
   wire        busy      = (q_cnt_r != 3'h0);
   wire        q_full    = (q_cnt_r == `Q_CNT_FULL);
   wire [3:0]  eff_len   = head[`E_BL8_BIT] ? 4'h8 : 4'h4;
   wire [3:0]  half_last = last[`E_BL8_BIT] ? 4'h4 : 4'h2;
   wire [3:0]  wtr_need  = ({1'b0, wtr_cfg_r} > `WTR_MIN) ? {1'b0, wtr_cfg_r} : `WTR_MIN;

   wire [1:0]  rdy_w;
   wire [15:0] hold_w;
   wire [1:0]  mask_w;
   wire        emit      = &rdy_w;
   wire        burst_end = emit && ((widx_r + 4'h1) == eff_len);
   wire        pop       = burst_end;
   wire        push      = wr_cmd & ~q_full;

   // Truncation only for a BL8 entry without auto precharge, two clocks on
   wire trunc_ok = wr_cmd & busy & last[`E_BL8_BIT] & ~last[`E_AP_BIT]
                   & (gap_r == `TRUNC_GAP);
   // Widened by one bit so a saturated spacing count cannot wrap to zero
   wire early    = wr_cmd & busy & (({1'b0, gap_r} + 5'h01) < {1'b0, half_last})
                   & ~trunc_ok;
   wire pre_busy = pre_cmd & (pre_hits(a10, cmd_bank, head[`E_BANK_MSB:`E_BANK_LSB])
                   | pre_hits(a10, cmd_bank, last[`E_BANK_MSB:`E_BANK_LSB]));
   wire v_int_set = early | (wr_cmd & q_full) | (busy & (rd_cmd | pre_busy));
   wire v_wtr_set = rd_cmd & ~busy & (since_end_r < wtr_need);
   wire v_wr_set  = pre_cmd & ~busy & pre_hits(a10, cmd_bank, last_bank_r)
                    & (since_end_r < {1'b0, wr_cfg_r});

   // Per-lane strobe capture, each lane on its own strobe
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : lane
         reg       started_r;
         reg       rdy_r;
         reg [7:0] hold_r;
         reg       mh_r;
         wire      rise = dqs_now[g] & ~dqs_prv[g];
         wire      fall = ~dqs_now[g] & dqs_prv[g];
         always @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               started_r <= 1'b0;
               rdy_r     <= 1'b0;
               hold_r    <= 8'h00;
               mh_r      <= 1'b0;
            end else if (burst_end) begin
               started_r <= 1'b0;
               rdy_r     <= 1'b0;
            end else begin
               if (emit) begin
                  rdy_r <= 1'b0;
               end
               if (busy && rise) begin
                  started_r <= 1'b1;
               end
               if (busy && (rise || (fall && started_r))) begin
                  hold_r <= s2_r[8*g+7:8*g];
                  mh_r   <= s2_r[18+g];
                  rdy_r  <= 1'b1;
               end
            end
         end
         assign rdy_w[g]            = rdy_r;
         assign hold_w[8*g+7:8*g]   = hold_r;
         assign mask_w[g]           = mh_r;
      end
   endgenerate

   // Command queue storage; entries are data, pointers carry the state
   always @(posedge mclk) begin
      if (push) begin
         q_mem[q_tail_r] <= {cfg_bl8_r, a10, cmd_col, cmd_bank};
      end
      if (trunc_ok) begin
         q_mem[tail_prev][`E_BL8_BIT] <= 1'b0;
      end
   end

   // Bank row state
   always @* begin
      bank_nxt = bank_open_r;
      if (burst_end && head[`E_AP_BIT]) begin
         bank_nxt[head[`E_BANK_MSB:`E_BANK_LSB]] = 1'b0;
      end
      if (act_cmd) begin
         bank_nxt[cmd_bank] = 1'b1;
      end
      if (pre_cmd) begin
         if (a10) begin
            bank_nxt = 8'h00;
         end else begin
            bank_nxt[cmd_bank] = 1'b0;
         end
      end
   end

   // Burst sequencing, counters and user write port
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         q_head_r    <= 2'h0;
         q_tail_r    <= 2'h0;
         q_cnt_r     <= 3'h0;
         widx_r      <= 4'h0;
         gap_r       <= `CNT_SAT;
         since_end_r <= `CNT_SAT;
         last_bank_r <= 3'h0;
         bank_open_r <= 8'h00;
         wcnt_r      <= 16'h0000;
         wr_valid    <= 1'b0;
         wr_bank     <= 3'h0;
         wr_col      <= 10'h000;
         wr_data     <= 16'h0000;
         wr_mask     <= 2'h0;
         dq_out      <= 16'h0000;
         dq_oe_n     <= 1'b1;
      end else begin
         bank_open_r <= bank_nxt;
         q_cnt_r     <= q_cnt_r + {2'h0, push} - {2'h0, pop};
         if (push) begin
            q_tail_r <= q_tail_r + 2'h1;
         end
         if (pop) begin
            q_head_r    <= q_head_r + 2'h1;
            last_bank_r <= head[`E_BANK_MSB:`E_BANK_LSB];
         end
         // Edges since the last WRITE, for spacing checks
         if (wr_cmd) begin
            gap_r <= 4'h0;
         end else if (ck_rise && gap_r != `CNT_SAT) begin
            gap_r <= gap_r + 4'h1;
         end
         // Recovery counted from the end of the last burst, at its truncated length if it was cut
         if (burst_end) begin
            since_end_r <= 4'h0;
         end else if (ck_rise && since_end_r != `CNT_SAT) begin
            since_end_r <= since_end_r + 4'h1;
         end
         if (burst_end) begin
            widx_r <= 4'h0;
         end else if (emit) begin
            widx_r <= widx_r + 4'h1;
         end
         wr_valid <= emit;
         if (emit) begin
            wr_bank <= head[`E_BANK_MSB:`E_BANK_LSB];
            wr_col  <= head[`E_COL_MSB:`E_COL_LSB] + {6'h00, widx_r};
            wr_data <= hold_w;
            wr_mask <= mask_w;
            wcnt_r  <= wcnt_r + 16'h0001;
         end
      end
   end

   // Register read mux
   always @* begin
      rd_mux = 32'h0000_0000;
      case (reg_sel(paddr))
         `SEL_CFG: begin
            rd_mux[`CFG_BL8_BIT]               = cfg_bl8_r;
            rd_mux[`CFG_WR_MSB:`CFG_WR_LSB]    = wr_cfg_r;
            rd_mux[`CFG_WTR_MSB:`CFG_WTR_LSB]  = wtr_cfg_r;
         end
         `SEL_STAT: begin
            rd_mux[7:0]                        = bank_open_r;
            rd_mux[`ST_BUSY_BIT]               = busy;
            rd_mux[`ST_VWR_BIT:`ST_VINT_BIT]   = viol_r;
            rd_mux[`ST_QCNT_MSB:`ST_QCNT_LSB]  = q_cnt_r;
         end
         `SEL_WCNT: begin
            rd_mux[15:0]                       = wcnt_r;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   wire apb_setup = psel & ~penable;
   wire apb_wr    = psel & penable & pwrite & pready;
   wire [1:0] wsel = reg_sel(paddr);

   // APB slave, one wait-free access cycle after setup
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prdata    <= 32'h0000_0000;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         cfg_bl8_r <= `BL8_RST;
         wr_cfg_r  <= `WR_RST;
         wtr_cfg_r <= `WTR_RST;
         viol_r    <= 3'h0;
      end else begin
         pready  <= apb_setup;
         pslverr <= apb_setup & (wsel == `SEL_NONE);
         if (apb_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end
         if (apb_wr && wsel == `SEL_CFG) begin
            cfg_bl8_r <= pwdata[`CFG_BL8_BIT];
            wtr_cfg_r <= pwdata[`CFG_WTR_MSB:`CFG_WTR_LSB];
            wr_cfg_r  <= pwdata[`CFG_WR_MSB:`CFG_WR_LSB];
         end
         // Sticky flags, write one to clear, a new event wins
         viol_r <= ((apb_wr && wsel == `SEL_STAT) ?
                    (viol_r & ~pwdata[`ST_VWR_BIT:`ST_VINT_BIT]) : viol_r)
                   | {v_wr_set, v_wtr_set, v_int_set};
      end
   end

endmodule

// ---- testbench/ddr2_wr_checker.sv ----
// Purpose: Port-level checks for the DDR2 write burst path.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bus checks tie an answer to its cause at the inputs, except the error-within-answer check; word and pin checks watch outputs alone.
module ddr2_wr_checker (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] dq_out,
   input wire logic        dq_oe_n,
   input wire logic        wr_valid,
   input wire logic [9:0]  wr_col,
   input wire logic [15:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Data pins are never driven
   property p_undriven; dq_oe_n && dq_out == 16'h0000; endproperty
   a_undriven: assert property (p_undriven) else $error("data pins driven");
   // One strobe per word, data and column hold between strobes
   property p_word_pulse; wr_valid |=> !wr_valid; endproperty
   a_word_pulse: assert property (p_word_pulse) else $error("word strobe long");
   property p_word_hold; !wr_valid |-> $stable(wr_data) && $stable(wr_col); endproperty
   a_word_hold: assert property (p_word_hold) else $error("word changed");
   // Bus answer one cycle after setup, for one cycle
   property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
   a_answer: assert property (p_answer) else $error("answer timing");
   property p_answer_cause; pready |-> $past(psel) && !$past(penable); endproperty
   a_answer_cause: assert property (p_answer_cause) else $error("answer without setup");
   property p_err_answer; pslverr |-> pready; endproperty
   a_err_answer: assert property (p_err_answer) else $error("error outside answer");
   property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
   property p_data_hold; !(psel && !penable) |=> $stable(prdata); endproperty
   a_data_hold: assert property (p_data_hold) else $error("read data moved");
endmodule

bind ddr2_write_burst_path ddr2_wr_checker u_chk (.mclk, .nrst, .psel, .penable, .pwrite,
   .prdata, .pready, .pslverr, .dq_out, .dq_oe_n, .wr_valid, .wr_col, .wr_data);

// ---- testbench/ddr2_ctrl_model.sv ----
// Purpose: Behavioural memory controller: commands, strobes, data and masks.
// Assumes: ck runs free; commands change on its falling edge.
// Notes:   Data is scheduled per ck edge, so a later WRITE overwrites a cut tail.
`include "ddr2_wr_consts.vh"
module ddr2_ctrl_model #(
   parameter int WL = 2
) (
   input  wire logic   ck,
   output logic        cs_n,
   output logic        ras_n,
   output logic        cas_n,
   output logic        we_n,
   output logic [2:0]  ba,
   output logic [13:0] addr,
   output logic [1:0]  dm,
   output logic        dqs_l,
   output logic        dqs_u,
   output logic [15:0] dq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] sd [0:2047];
   bit          sv [0:2047];
   int          h = -1;
   int          kr = 0;
   // Idle pins at time zero
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      {ba, addr, dm, dqs_l, dqs_u, dq} = 37'h0;
   end
   // One command across one ck rise, then deselect with moving address
   task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
      @(negedge ck);
      // Rise index of this command, whichever way the edge count race falls
      kr = (h | 1) + 1;
      {cs_n, ras_n, cas_n, we_n} = {1'b0, c};
      ba = b;
      addr = a;
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      ba = ~b;
      addr = ~a;
   endtask
   // WRITE, first element WL clocks later, one per strobe edge
   task automatic wr(input logic [2:0] b, input logic [9:0] col, input logic ap,
                     input int n, input logic [15:0] base);
      cmd(`CMD_WRITE, b, {3'h0, ap, col});
      for (int i = 0; i < n; i++) begin
         sd[kr + 2 * WL + i] = {i[1:0], base + i[15:0]};
         sv[kr + 2 * WL + i] = 1'b1;
      end
   endtask
   // Strobe edges with no WRITE behind them
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         sd[(h | 1) + 3 + i] = 18'h0EE00;
         sv[(h | 1) + 3 + i] = 1'b1;
      end
   endtask
   // Strobe on ck edges, low outside bursts; data moves a quarter clock early
   always @(ck) begin
      h = h + 1;
      dqs_l = sv[h] && !h[0];
      dqs_u = dqs_l;
      #100;
      dq = sv[h + 1] ? sd[h + 1][15:0] : ~dq;
      dm = sv[h + 1] ? sd[h + 1][17:16] : ~dm;
   end
endmodule

// ---- testbench/tb_ddr2_write_burst_path.sv ----
// Purpose: Self-checking bench for the DDR2 write burst path.
// Assumes: APB answers within a few cycles; ck free-running at 400 ns.
// Notes:   Captured words are queued and compared with expected bursts.
`include "ddr2_wr_consts.vh"
module tb_ddr2_write_burst_path;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        ck = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, cs_n, ras_n, cas_n, we_n, dqs_l, dqs_u;
   logic        dq_oe_n, wr_valid;
   logic [2:0]  ba, wr_bank;
   logic [13:0] addr;
   logic [1:0]  dm, wr_mask;
   logic [15:0] dq, dq_out, wr_data;
   logic [9:0]  wr_col;
   logic [30:0] got[$], exq[$];
   int          failures = 0;
   int          samples_checked = 0;

   always #25 mclk = ~mclk;
   initial #7 forever #200 ck = ~ck;

   ddr2_ctrl_model m (.ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dm, .dqs_l, .dqs_u, .dq);
   ddr2_write_burst_path DUT (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dm, .dqs_l, .dqs_u,
      .dq_in(dq), .dq_out, .dq_oe_n, .wr_valid, .wr_bank, .wr_col, .wr_data, .wr_mask);

   // Every captured word, in order
   always @(posedge mclk) begin
      if (wr_valid === 1'b1) got.push_back({wr_bank, wr_col, wr_data, wr_mask});
   end
   task automatic chk(input logic [31:0] e, input logic [31:0] a);
      samples_checked++;
      if (a !== e) begin
         failures++;
         $display("unexpected at %0t: expected %h got %h", $time, e, a);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) failures++;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(e, rd & mask);
   endtask
   task automatic want(input logic [2:0] b, input logic [9:0] col, input int n,
                       input logic [15:0] base);
      for (int i = 0; i < n; i++) exq.push_back({b, col + i[9:0], base + i[15:0], i[1:0]});
   endtask
   // Wait for expected words, let stragglers arrive, compare in order
   task automatic drain;
      int t;
      t = 0;
      while (got.size() < exq.size() && t < 4000) begin
         @(posedge mclk);
         t++;
      end
      repeat (48) @(posedge mclk);
      chk(exq.size(), got.size());
      while (exq.size() > 0 && got.size() > 0)
         chk({1'b0, exq.pop_front()}, {1'b0, got.pop_front()});
      exq.delete();
      got.delete();
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      // Reset value, then an unmapped word is refused
      rreg(`ADDR_CFG, 32'h0000_0771, 32'h0000_0230);
      apb(1'b0, 8'h0C, 32'h0);
      chk(32'h1, {31'h0, err});
      chk(32'h0, rd);
      // Four-element bursts back to back; bank 1 stays open, bank 2 auto-closes
      apb(1'b1, `ADDR_CFG, 32'h0000_0770);
      m.cmd(`CMD_ACT, 3'h1, 14'h0011);
      m.cmd(`CMD_ACT, 3'h2, 14'h0022);
      m.wr(3'h1, 10'h004, 1'b0, 4, 16'hA500);
      m.wr(3'h2, 10'h010, 1'b1, 4, 16'h5A00);
      want(3'h1, 10'h004, 4, 16'hA500);
      want(3'h2, 10'h010, 4, 16'h5A00);
      drain;
      rreg(`ADDR_STAT, 32'h0000_0FFF, 32'h0000_0002);
      // Strobes after the bursts carry no words
      m.stray(6);
      drain;
      rreg(`ADDR_WCNT, 32'h0000_FFFF, 32'h0000_0008);
      // Eight-element burst cut by a WRITE two clocks later to the same bank
      apb(1'b1, `ADDR_CFG, 32'h0000_0771);
      m.cmd(`CMD_ACT, 3'h3, 14'h0033);
      m.wr(3'h3, 10'h020, 1'b0, 8, 16'hC000);
      m.wr(3'h3, 10'h040, 1'b1, 8, 16'h3C00);
      want(3'h3, 10'h020, 4, 16'hC000);
      want(3'h3, 10'h040, 8, 16'h3C00);
      drain;
      rreg(`ADDR_STAT, 32'h0000_0FFF, 32'h0000_0002);
      // Early READ and PRECHARGE with seven-clock recovery and turnaround
      m.wr(3'h1, 10'h080, 1'b0, 8, 16'h7700);
      repeat (3) m.cmd(3'h7, 3'h0, 14'h0000);
      m.cmd(`CMD_PRE, 3'h0, 14'h0000);
      m.cmd(`CMD_READ, 3'h1, 14'h0000);
      rreg(`ADDR_STAT, 32'h0000_0E00, 32'h0000_0400);
      m.cmd(`CMD_PRE, 3'h1, 14'h0000);
      rreg(`ADDR_STAT, 32'h0000_0E00, 32'h0000_0C00);
      apb(1'b1, `ADDR_STAT, 32'h0000_0E00);
      rreg(`ADDR_STAT, 32'h0000_0E00, 32'h0000_0000);
      // Precharge while a burst is in flight raises the interrupt flag
      m.wr(3'h4, 10'h100, 1'b0, 8, 16'h1100);
      m.cmd(`CMD_PRE, 3'h4, 14'h0000);
      rreg(`ADDR_STAT, 32'h0000_0E00, 32'h0000_0200);
      want(3'h1, 10'h080, 8, 16'h7700);
      want(3'h4, 10'h100, 8, 16'h1100);
      drain;
      final_report;
   end
   // Cut a hang short
   initial begin
      #400000;
      failures++;
      final_report;
   end
endmodule
